// ===== logic/smfh_link_if.sv
// Two-wire link between the bus master end and the slave device end
`timescale 1ns/10ps
interface smfh_link_if;
   logic scl;
   logic frame;
   logic m_sda_o;
   logic m_sda_oe;
   logic d_sda_o;
   logic d_sda_oe;
   logic sda_i;

   // Wired-AND of the open-drain data line
   assign sda_i = ~((m_sda_oe & ~m_sda_o) | (d_sda_oe & ~d_sda_o));

   modport master (output scl, output frame, output m_sda_o, output m_sda_oe, input sda_i);
   modport slave  (input scl, input frame, input sda_i, output d_sda_o, output d_sda_oe);
endinterface

// ===== logic/smfh_master_end.sv
// Link master end: divides its clock into the link clock and sends write frames
`timescale 1ns/10ps
module smfh_master_end #(
   parameter int unsigned SCL_HALF_DIV = smfh_pkg::SCL_HALF_DIV
) (
   input  wire logic                          i_clk_sys,
   input  wire logic                          i_rst,
   smfh_link_if.master                        link,
   input  wire logic                          i_start,
   input  wire logic [smfh_pkg::ADDR_W-1:0]   i_addr,
   input  wire logic [smfh_pkg::BYTE_W-1:0]   i_byte,
   input  wire logic                          i_last,
   input  wire logic                          i_debug,
   input  wire logic                          i_halt_in_debug,
   output logic                               o_busy,
   output logic                               o_byte_done,
   output logic                               o_nack,
   output logic                               o_halted
);
   import smfh_pkg::*;

   smfh_mstate_e             state_r;
   logic [DIV_W-1:0]         div_cnt_r;
   logic                     scl_r;
   logic                     frame_r;
   logic                     sda_oe_r;
   logic [1:0]               sda_s_r;
   logic [2:0]               bit_cnt_r;
   logic [BYTE_W-1:0]        shift_r;
   logic [ADDR_W-1:0]        addr_r;
   logic                     pend_r;
   logic                     last_r;
   logic                     tick;
   logic                     fall;
   logic                     rise;

   assign tick = (div_cnt_r == DIV_W'(SCL_HALF_DIV - 1)) && (state_r != M_HALT);
   assign fall = tick & scl_r;
   assign rise = tick & ~scl_r;

   assign link.scl      = scl_r;
   assign link.frame    = frame_r;
   assign link.m_sda_o  = 1'b0;
   assign link.m_sda_oe = sda_oe_r;

   // Data line sampled through two flip-flops
   always_ff @(posedge i_clk_sys) begin
      sda_s_r <= {sda_s_r[0], link.sda_i};
   end

   // Link clock divider, frozen while halted
   always_ff @(posedge i_clk_sys) begin
      if (i_rst || state_r == M_HALT || tick) begin
         div_cnt_r <= '0;
      end else begin
         div_cnt_r <= div_cnt_r + DIV_W'(1);
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         scl_r <= 1'b1;
      end else if (tick) begin
         scl_r <= ~scl_r;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         state_r     <= M_IDLE;
         frame_r     <= 1'b0;
         sda_oe_r    <= 1'b0;
         bit_cnt_r   <= '0;
         shift_r     <= '0;
         addr_r      <= '0;
         pend_r      <= 1'b0;
         last_r      <= 1'b0;
         o_busy      <= 1'b0;
         o_byte_done <= 1'b0;
         o_nack      <= 1'b0;
         o_halted    <= 1'b0;
      end else begin
         o_byte_done <= 1'b0;
         unique case (state_r)
            M_IDLE: begin
               if (i_start && !pend_r) begin
                  addr_r <= i_addr;
                  pend_r <= 1'b1;
                  o_busy <= 1'b1;
                  o_nack <= 1'b0;
               end else if (pend_r && fall) begin
                  pend_r    <= 1'b0;
                  frame_r   <= 1'b1;
                  shift_r   <= {addr_r, 1'b0};
                  sda_oe_r  <= ~addr_r[ADDR_W-1];
                  bit_cnt_r <= '0;
                  last_r    <= 1'b0;
                  state_r   <= M_SEND;
               end
            end
            M_SEND: begin
               if (fall) begin
                  if (bit_cnt_r == BIT_LAST) begin
                     sda_oe_r <= 1'b0;
                     state_r  <= M_ACK;
                  end else begin
                     shift_r   <= {shift_r[BYTE_W-2:0], 1'b0};
                     sda_oe_r  <= ~shift_r[BYTE_W-2];
                     bit_cnt_r <= bit_cnt_r + 3'h1;
                  end
               end
            end
            M_ACK: begin
               if (rise) begin
                  o_nack <= sda_s_r[1];
               end else if (fall) begin
                  o_byte_done <= 1'b1;
                  bit_cnt_r   <= '0;
                  if (o_nack || last_r) begin
                     frame_r <= 1'b0;
                     o_busy  <= 1'b0;
                     state_r <= M_IDLE;
                  end else if (i_debug && i_halt_in_debug) begin
                     o_halted <= 1'b1;
                     state_r  <= M_HALT;
                  end else begin
                     shift_r  <= i_byte;
                     last_r   <= i_last;
                     sda_oe_r <= ~i_byte[BYTE_W-1];
                     state_r  <= M_SEND;
                  end
               end
            end
            M_HALT: begin
               if (!i_debug) begin
                  o_halted <= 1'b0;
                  shift_r  <= i_byte;
                  last_r   <= i_last;
                  sda_oe_r <= ~i_byte[BYTE_W-1];
                  state_r  <= M_SEND;
               end
            end
            default: begin
               state_r <= M_IDLE;
            end
         endcase
      end
   end
endmodule

// ===== logic/smfh_pkg.sv
// Shared constants and types for the serial module flag-handling block
package smfh_pkg;

   // Register port geometry
   localparam int          REG_AW        = 3;
   localparam int          REG_DW        = 8;
   localparam int          BYTE_W        = 8;
   localparam int          ADDR_W        = 7;

   // Register indices
   localparam logic [2:0]  REG_PRIMARY   = 3'h0;
   localparam logic [2:0]  REG_SECONDARY = 3'h1;
   localparam logic [2:0]  REG_FLAGS     = 3'h2;
   localparam logic [2:0]  REG_STATUS    = 3'h3;
   localparam logic [2:0]  REG_DATA      = 3'h4;
   localparam logic [2:0]  REG_ADDR      = 3'h5;

   // primary_control_reg fields
   localparam int          P_ENABLE      = 0;
   localparam int          P_SMART       = 1;
   localparam int          P_LOWTO       = 2;
   localparam int          P_SEXT        = 3;
   localparam int          P_MEXT        = 4;
   localparam int          P_AUTOBAUD    = 5;

   // secondary_control_reg fields (command field is write-only)
   localparam int          S_ACKNOWLEDGE_ACTION_BIT      = 0;
   localparam int          S_CMD_LSB     = 1;
   localparam int          S_CMD_MSB     = 2;
   localparam int          S_RECEIVER_ENABLE_BIT        = 3;
   localparam int          S_SLDE        = 4;

   // interrupt_flag_reg fields
   localparam int          F_ADDRESS_MATCH_FLAG      = 0;
   localparam int          F_DATA_READY_FLAG        = 1;
   localparam int          F_STOP        = 2;
   localparam int          F_SSL         = 3;
   localparam int          F_FRAMING_ERROR_FLAG        = 4;
   localparam int          F_LOWTO       = 5;
   localparam int          F_EXTTO       = 6;

   // status_reg fields
   localparam int          ST_BUSY       = 0;
   localparam int          ST_ARMED      = 1;
   localparam int          ST_SLOWREQ    = 2;

   // Masks and reset values
   localparam logic [7:0]  PRIMARY_MASK  = 8'h3F;
   localparam logic [7:0]  SECONDARY_MASK = 8'h19;
   localparam logic [7:0]  PRIMARY_RST   = 8'h00;
   localparam logic [7:0]  SECONDARY_RST = 8'h00;
   localparam logic [7:0]  FLAGS_RST     = 8'h00;
   localparam logic [6:0]  ADDR_RST      = 7'h10;

   // Slave commands
   localparam logic [1:0]  CMD_CLOSE     = 2'h2;
   localparam logic [1:0]  CMD_CLEAR_ALL = 2'h3;

   // Link bit counting
   localparam logic [2:0]  BIT_LAST      = 3'h7;

   // Timing
   localparam int          SYS_CLK_MHZ   = 20;
   localparam int          LOW_TO_US     = 25000;
   localparam int          EXT_TO_US     = 10000;
   localparam int          LOW_TO_CYC    = LOW_TO_US * SYS_CLK_MHZ;
   localparam int          EXT_TO_CYC    = EXT_TO_US * SYS_CLK_MHZ;
   localparam int          TO_CNT_W      = 20;
   localparam int          SCL_HALF_DIV  = 2;
   localparam int          DIV_W         = 8;

   // Link master states
   typedef enum logic [3:0] {
      M_IDLE = 4'b0001,
      M_SEND = 4'b0010,
      M_ACK  = 4'b0100,
      M_HALT = 4'b1000
   } smfh_mstate_e;

endpackage

// ===== logic/smfh_slave_dev.sv
// Serial module slave end: link-clocked receiver and register-side flag handling
//
// What this block does
// - Mid-transaction control writes may reset slave logic
// - Command three clears every slave flag
// - Writing one clears the address-match flag
// - Smart mode: data access clears data-ready
// - Without smart mode, only write-one or command three clears data-ready
// - Clear acknowledge: status zero, then control zero
// - Set acknowledge: status zero, then control bit
// - Extend timeouts need low-timeout enable; slow clock
// - Auto-baud hides mid-byte stop as error
// - Enable first, receiver later, avoids false select
// - Debug halt stops master after current byte
`timescale 1ns/10ps
module smfh_slave_dev #(
   parameter int unsigned LOW_TO_CYC = smfh_pkg::LOW_TO_CYC,
   parameter int unsigned EXT_TO_CYC = smfh_pkg::EXT_TO_CYC
) (
   input  wire logic                          i_clk_sys,
   input  wire logic                          i_rst,
   smfh_link_if.slave                         link,
   input  wire logic                          i_reg_wr,
   input  wire logic                          i_reg_rd,
   input  wire logic [smfh_pkg::REG_AW-1:0]   i_reg_addr,
   input  wire logic [smfh_pkg::REG_DW-1:0]   i_reg_wdata,
   output logic      [smfh_pkg::REG_DW-1:0]   o_reg_rdata,
   output logic                               o_slow_clk_req
);
   import smfh_pkg::*;

   // Register side state
   logic [REG_DW-1:0]   primary_r;
   logic [REG_DW-1:0]   secondary_r;
   logic [REG_DW-1:0]   flags_r;
   logic [REG_DW-1:0]   flags_nxt;
   logic [BYTE_W-1:0]   data_r;
   logic [ADDR_W-1:0]   addr_r;
   logic                armed_r;
   logic                fsr_tgl_r;
   logic [2:0]          am_s_r;
   logic [2:0]          dr_s_r;
   logic [2:0]          sm_s_r;
   logic [2:0]          fr_s_r;
   logic [1:0]          scl_s_r;
   logic [TO_CNT_W-1:0] low_cnt_r;
   logic [TO_CNT_W-1:0] ext_cnt_r;

   // Link side state
   logic                rst_l1_r;
   logic                rst_l2_r;
   logic                lrst_r;
   logic [1:0]          lack_s_r;
   logic                ev_gate;
   logic                ack_l1_r;
   logic                ack_l2_r;
   logic [ADDR_W-1:0]   addr_l1_r;
   logic [ADDR_W-1:0]   addr_l2_r;
   logic [2:0]          fsr_l_r;
   logic [2:0]          bit_cnt_r;
   logic [BYTE_W-1:0]   shift_r;
   logic [BYTE_W-1:0]   rx_byte_r;
   logic                in_addr_r;
   logic                matched_r;
   logic                ack_slot_r;
   logic                sda_oe_r;
   logic                frame_prev_r;
   logic                am_tgl_r;
   logic                dr_tgl_r;
   logic                sm_tgl_r;

   logic [BYTE_W-1:0]   byte_in;
   logic                link_idle;
   logic                byte_end;
   logic                addr_hit;

   // Register side decode and events
   logic                wr_primary;
   logic                wr_secondary;
   logic                wr_flags;
   logic                wr_status;
   logic                data_access;
   logic [1:0]          wr_cmd;
   logic                am_ev;
   logic                dr_ev;
   logic                sm_ev;
   logic                frame_rise;
   logic                frame_fall;
   logic                ssl_ev;
   logic                low_run;
   logic                ext_run;
   logic                low_hit;
   logic                ext_hit;

   // ---------------- Link clock domain ----------------
   assign byte_in   = {shift_r[BYTE_W-2:0], link.sda_i};
   assign link_idle = rst_l2_r | (fsr_l_r[1] ^ fsr_l_r[2]) | ~link.frame;
   assign byte_end  = ~link_idle & ~ack_slot_r & (bit_cnt_r == BIT_LAST);
   assign addr_hit  = byte_in[BYTE_W-1:1] == addr_l2_r;
   assign link.d_sda_o  = 1'b0;
   assign link.d_sda_oe = sda_oe_r;

   // Levels and toggles from the register side
   always_ff @(posedge link.scl) begin
      rst_l1_r  <= lrst_r;
      rst_l2_r  <= rst_l1_r;
      ack_l1_r  <= primary_r[P_ENABLE] & ~secondary_r[S_ACKNOWLEDGE_ACTION_BIT];
      ack_l2_r  <= ack_l1_r;
      addr_l1_r <= addr_r;
      addr_l2_r <= addr_l1_r;
      fsr_l_r   <= {fsr_l_r[1:0], fsr_tgl_r};
   end

   // Bit engine: sample on rising link clock, acknowledge in ninth slot
   always_ff @(posedge link.scl) begin
      if (link_idle) begin
         bit_cnt_r  <= '0;
         in_addr_r  <= 1'b1;
         matched_r  <= 1'b0;
         ack_slot_r <= 1'b0;
         sda_oe_r   <= 1'b0;
      end else if (ack_slot_r) begin
         ack_slot_r <= 1'b0;
         sda_oe_r   <= 1'b0;
      end else begin
         shift_r   <= byte_in;
         bit_cnt_r <= bit_cnt_r + 3'h1;
         if (byte_end) begin
            ack_slot_r <= 1'b1;
            if (in_addr_r) begin
               in_addr_r <= 1'b0;
               matched_r <= addr_hit;
               sda_oe_r  <= addr_hit & ack_l2_r;
            end else begin
               sda_oe_r  <= matched_r & ack_l2_r;
            end
         end
      end
   end

   // Events toward the register side
   always_ff @(posedge link.scl) begin
      if (rst_l2_r) begin
         am_tgl_r     <= 1'b0;
         dr_tgl_r     <= 1'b0;
         sm_tgl_r     <= 1'b0;
         rx_byte_r    <= '0;
         frame_prev_r <= 1'b0;
      end else begin
         frame_prev_r <= link.frame;
         if (byte_end && in_addr_r && addr_hit) begin
            am_tgl_r <= ~am_tgl_r;
         end
         if (byte_end && !in_addr_r && matched_r) begin
            rx_byte_r <= byte_in;
            dr_tgl_r  <= ~dr_tgl_r;
         end
         if (frame_prev_r && !link.frame && bit_cnt_r != 3'h0) begin
            sm_tgl_r <= ~sm_tgl_r;
         end
      end
   end

   // ---------------- Register clock domain ----------------
   always_ff @(posedge i_clk_sys) begin
      am_s_r  <= {am_s_r[1:0], am_tgl_r};
      dr_s_r  <= {dr_s_r[1:0], dr_tgl_r};
      sm_s_r  <= {sm_s_r[1:0], sm_tgl_r};
      fr_s_r  <= {fr_s_r[1:0], link.frame};
      scl_s_r <= {scl_s_r[0], link.scl};
   end

   // Link reset held until the running link clock has carried it over
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         lrst_r   <= 1'b1;
         lack_s_r <= 2'b00;
      end else begin
         lack_s_r <= {lack_s_r[0], rst_l2_r};
         if (lack_s_r[1]) begin
            lrst_r <= 1'b0;
         end
      end
   end

   assign ev_gate    = lrst_r | lack_s_r[1];
   assign am_ev      = (am_s_r[2] ^ am_s_r[1]) & ~ev_gate;
   assign dr_ev      = (dr_s_r[2] ^ dr_s_r[1]) & ~ev_gate;
   assign sm_ev      = (sm_s_r[2] ^ sm_s_r[1]) & ~ev_gate;
   assign frame_rise = fr_s_r[1] & ~fr_s_r[2];
   assign frame_fall = ~fr_s_r[1] & fr_s_r[2];

   assign wr_primary   = i_reg_wr && i_reg_addr == REG_PRIMARY;
   assign wr_secondary = i_reg_wr && i_reg_addr == REG_SECONDARY;
   assign wr_flags     = i_reg_wr && i_reg_addr == REG_FLAGS;
   assign wr_status    = i_reg_wr && i_reg_addr == REG_STATUS;
   assign data_access  = (i_reg_wr || i_reg_rd) && i_reg_addr == REG_DATA;
   assign wr_cmd       = i_reg_wdata[S_CMD_MSB:S_CMD_LSB];

   // Select-low event, including the false one on enable with receiver on
   assign ssl_ev = (frame_rise & primary_r[P_ENABLE] & secondary_r[S_RECEIVER_ENABLE_BIT]
                    & secondary_r[S_SLDE])
                 | (wr_primary & i_reg_wdata[P_ENABLE] & ~primary_r[P_ENABLE]
                    & secondary_r[S_RECEIVER_ENABLE_BIT] & secondary_r[S_SLDE]);

   // Control registers and the guarded-write arming
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         primary_r   <= PRIMARY_RST;
         secondary_r <= SECONDARY_RST;
         addr_r      <= ADDR_RST;
         armed_r     <= 1'b0;
         fsr_tgl_r   <= 1'b0;
      end else begin
         if (wr_primary) begin
            primary_r <= i_reg_wdata & PRIMARY_MASK;
         end
         if (i_reg_wr && i_reg_addr == REG_ADDR) begin
            addr_r <= i_reg_wdata[ADDR_W-1:0];
         end
         if (wr_status && i_reg_wdata == '0) begin
            armed_r <= 1'b1;
         end else if (wr_secondary) begin
            armed_r <= 1'b0;
         end
         if (wr_secondary) begin
            secondary_r <= i_reg_wdata & SECONDARY_MASK;
            if ((flags_r[F_ADDRESS_MATCH_FLAG] || flags_r[F_DATA_READY_FLAG]) && !armed_r
                && wr_cmd != CMD_CLOSE) begin
               fsr_tgl_r <= ~fsr_tgl_r;
            end
         end
      end
   end

   // Flags: clears first, then sets, so a same-cycle event survives
   always_comb begin
      flags_nxt = flags_r;
      if (wr_flags) begin
         flags_nxt = flags_nxt & ~i_reg_wdata;
      end
      if (wr_secondary && wr_cmd == CMD_CLEAR_ALL) begin
         flags_nxt = '0;
      end
      if (data_access && primary_r[P_SMART]) begin
         flags_nxt[F_DATA_READY_FLAG] = 1'b0;
      end
      flags_nxt[F_ADDRESS_MATCH_FLAG] = flags_nxt[F_ADDRESS_MATCH_FLAG] | am_ev;
      flags_nxt[F_DATA_READY_FLAG]   = flags_nxt[F_DATA_READY_FLAG] | dr_ev;
      flags_nxt[F_STOP]   = flags_nxt[F_STOP] | frame_fall;
      flags_nxt[F_SSL]    = flags_nxt[F_SSL] | ssl_ev;
      flags_nxt[F_FRAMING_ERROR_FLAG]   = flags_nxt[F_FRAMING_ERROR_FLAG] | (sm_ev & ~primary_r[P_AUTOBAUD]);
      flags_nxt[F_LOWTO]  = flags_nxt[F_LOWTO] | low_hit;
      flags_nxt[F_EXTTO]  = flags_nxt[F_EXTTO] | ext_hit;
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         flags_r <= FLAGS_RST;
      end else begin
         flags_r <= flags_nxt;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         data_r <= '0;
      end else if (dr_ev) begin
         data_r <= rx_byte_r;
      end
   end

   // Timeouts run only with the low-timeout enable set
   assign low_run = fr_s_r[1] & ~scl_s_r[1] & primary_r[P_LOWTO];
   assign ext_run = fr_s_r[1] & primary_r[P_LOWTO]
                    & (primary_r[P_SEXT] | primary_r[P_MEXT]);
   assign low_hit = low_run && low_cnt_r == TO_CNT_W'(LOW_TO_CYC - 1);
   assign ext_hit = ext_run && ext_cnt_r == TO_CNT_W'(EXT_TO_CYC - 1);

   always_ff @(posedge i_clk_sys) begin
      if (i_rst || !low_run) begin
         low_cnt_r <= '0;
      end else if (!low_hit) begin
         low_cnt_r <= low_cnt_r + TO_CNT_W'(1);
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst || !ext_run) begin
         ext_cnt_r <= '0;
      end else if (!ext_hit) begin
         ext_cnt_r <= ext_cnt_r + TO_CNT_W'(1);
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         o_slow_clk_req <= 1'b0;
      end else begin
         o_slow_clk_req <= primary_r[P_ENABLE] & primary_r[P_LOWTO];
      end
   end

   // Registered read data, zero for unmapped indices
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         o_reg_rdata <= '0;
      end else if (i_reg_rd) begin
         unique case (i_reg_addr)
            REG_PRIMARY:   o_reg_rdata <= primary_r;
            REG_SECONDARY: o_reg_rdata <= secondary_r;
            REG_FLAGS:     o_reg_rdata <= flags_r;
            REG_STATUS:    o_reg_rdata <= {5'h00, o_slow_clk_req, armed_r, fr_s_r[1]};
            REG_DATA:      o_reg_rdata <= data_r;
            REG_ADDR:      o_reg_rdata <= {1'b0, addr_r};
            default:       o_reg_rdata <= '0;
         endcase
      end
   end
endmodule

// ===== test/serial_module_i2c_flag_handling_tb.sv
// Testbench joining the master end and the slave end over the link
`timescale 1ns/10ps
module serial_module_i2c_flag_handling_tb;
   import smfh_pkg::*;
   logic        i_clk_sys, i_rst, i_start, i_last, i_debug, i_halt_in_debug;
   logic        i_reg_wr, i_reg_rd, o_busy, o_byte_done, o_nack, o_halted;
   logic        o_slow_clk_req, rd_seen;
   logic [6:0]  i_addr;
   logic [7:0]  i_byte, i_reg_wdata, o_reg_rdata, last_b;
   logic [2:0]  i_reg_addr;
   logic [15:0] exp_q[$];
   logic [15:0] e;
   logic [7:0]  pv[3] = '{8'h19, 8'h05, 8'h04};
   logic        ev[3] = '{1'b0, 1'b1, 1'b0};
   int          miscompares, checks, seed, n;

   smfh_link_if smfh_link_if_i ();
   smfh_master_end #(.SCL_HALF_DIV(4)) smfh_master_end_i (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
      .link(smfh_link_if_i), .i_start(i_start), .i_addr(i_addr), .i_byte(i_byte),
      .i_last(i_last), .i_debug(i_debug), .i_halt_in_debug(i_halt_in_debug), .o_busy(o_busy),
      .o_byte_done(o_byte_done), .o_nack(o_nack), .o_halted(o_halted));
   smfh_slave_dev #(.LOW_TO_CYC(40), .EXT_TO_CYC(100)) smfh_slave_dev_i (.i_clk_sys(i_clk_sys),
      .i_rst(i_rst), .link(smfh_link_if_i), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
      .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
      .o_slow_clk_req(o_slow_clk_req));
   smfh_link_sva #(.SCL_HALF_DIV(4)) smfh_link_sva_i (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
      .scl(smfh_link_if_i.scl), .frame(smfh_link_if_i.frame), .m_sda_o(smfh_link_if_i.m_sda_o),
      .m_sda_oe(smfh_link_if_i.m_sda_oe), .d_sda_o(smfh_link_if_i.d_sda_o),
      .d_sda_oe(smfh_link_if_i.d_sda_oe), .sda_i(smfh_link_if_i.sda_i));

   initial begin
      i_clk_sys = 1'b0;
      forever #25 i_clk_sys = ~i_clk_sys;
   end

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic close_out();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   // Read results are compared one cycle after the read strobe
   always @(posedge i_clk_sys) begin
      if (rd_seen) begin
         e = exp_q.pop_front();
         chk("register read", e[7:0], o_reg_rdata & e[15:8]);
      end
      rd_seen <= i_reg_rd;
   end

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      i_reg_addr = a;
      i_reg_wdata = d;
      i_reg_wr = 1'b1;
      @(negedge i_clk_sys);
      i_reg_wr = 1'b0;
      @(negedge i_clk_sys);
   endtask

   task automatic rd(input logic [2:0] a, input logic [7:0] m, input logic [7:0] x);
      exp_q.push_back({m, x});
      i_reg_addr = a;
      i_reg_rd = 1'b1;
      @(negedge i_clk_sys);
      i_reg_rd = 1'b0;
      @(negedge i_clk_sys);
   endtask

   task automatic frame(input logic [6:0] a, input int nb, input logic xn);
      i_addr = a;
      i_byte = 8'($random(seed));
      last_b = i_byte;
      i_last = (nb == 1);
      i_start = 1'b1;
      @(negedge i_clk_sys);
      i_start = 1'b0;
      for (int k = 0; k < (xn ? 1 : nb + 1); k++) begin
         n = 0;
         while (o_byte_done !== 1'b1 && n < 2000) begin
            @(negedge i_clk_sys);
            n++;
         end
         if (n == 2000) begin
            miscompares++;
            close_out();
         end
         chk("halted", {7'h00, i_debug & i_halt_in_debug}, {7'h00, o_halted});
         if (o_halted === 1'b1) begin
            repeat (20) @(negedge i_clk_sys);
            chk("link clock held", 8'h00, {7'h00, smfh_link_if_i.scl});
            i_debug = 1'b0;
         end
         @(negedge i_clk_sys);
         if (k + 2 <= nb) begin
            i_byte = 8'($random(seed));
            last_b = i_byte;
            i_last = (k + 2 == nb);
         end
      end
      repeat (100) @(negedge i_clk_sys);
      chk("busy", 8'h00, {7'h00, o_busy});
      chk("nack", {7'h00, xn}, {7'h00, o_nack});
   endtask

   initial begin
      seed = 73;
      {miscompares, checks, n} = '0;
      {i_start, i_last, i_debug, i_halt_in_debug, i_reg_wr, i_reg_rd} = '0;
      {i_addr, i_byte, i_reg_wdata, i_reg_addr} = '0;
      i_rst = 1'b1;
      repeat (20) @(negedge i_clk_sys);
      i_rst = 1'b0;
      repeat (40) @(negedge i_clk_sys);
      // Reset values and an unmapped index
      rd(REG_PRIMARY, 8'hFF, PRIMARY_RST);
      rd(REG_FLAGS, 8'hFF, FLAGS_RST);
      rd(REG_ADDR, 8'h7F, {1'b0, ADDR_RST});
      rd(3'h6, 8'hFF, 8'h00);
      // Plain mode: flags stay until a one is written
      wr(REG_PRIMARY, 8'h01);
      frame(ADDR_RST, 1, 1'b0);
      rd(REG_DATA, 8'hFF, last_b);
      rd(REG_FLAGS, 8'h07, 8'h07);
      wr(REG_FLAGS, 8'h00);
      rd(REG_FLAGS, 8'h03, 8'h03);
      wr(REG_FLAGS, 8'h01);
      rd(REG_FLAGS, 8'h03, 8'h02);
      wr(REG_FLAGS, 8'h02);
      rd(REG_FLAGS, 8'h03, 8'h00);
      // Smart mode: data read and data write both clear data ready
      wr(REG_PRIMARY, 8'h03);
      frame(ADDR_RST, 2, 1'b0);
      rd(REG_DATA, 8'hFF, last_b);
      rd(REG_FLAGS, 8'h03, 8'h01);
      frame(ADDR_RST, 1, 1'b0);
      wr(REG_DATA, 8'h00);
      rd(REG_FLAGS, 8'h06, 8'h04);
      // Command three clears every flag, stop included
      wr(REG_STATUS, 8'h00);
      wr(REG_SECONDARY, 8'h06);
      rd(REG_FLAGS, 8'hFF, 8'h00);
      // Acknowledge action set, then cleared, each armed by a status write
      wr(REG_STATUS, 8'h00);
      wr(REG_SECONDARY, 8'h01);
      frame(ADDR_RST, 1, 1'b1);
      wr(REG_STATUS, 8'h00);
      wr(REG_SECONDARY, 8'h00);
      frame(ADDR_RST, 1, 1'b0);
      // Debug with and without the halt bit
      for (int h = 0; h < 2; h++) begin
         i_debug = 1'b1;
         i_halt_in_debug = h[0];
         frame(ADDR_RST, 2, 1'b0);
      end
      i_debug = 1'b0;
      // Wrong address, and auto-baud with whole bytes
      wr(REG_FLAGS, 8'h7F);
      wr(REG_PRIMARY, 8'h21);
      frame(ADDR_RST ^ 7'h01, 1, 1'b1);
      rd(REG_FLAGS, 8'h13, 8'h00);
      // Slow clock request needs the low-timeout enable
      for (int i = 0; i < 3; i++) begin
         wr(REG_PRIMARY, pv[i]);
         chk("slow clock request", {7'h00, ev[i]}, {7'h00, o_slow_clk_req});
         rd(REG_STATUS, 8'h04, {5'h00, ev[i], 2'h0});
      end
      // Select-low: enable first then receiver is clean, the other order flags
      wr(REG_PRIMARY, 8'h00);
      wr(REG_FLAGS, 8'h7F);
      wr(REG_SECONDARY, 8'h10);
      wr(REG_PRIMARY, 8'h01);
      wr(REG_SECONDARY, 8'h18);
      rd(REG_FLAGS, 8'h08, 8'h00);
      wr(REG_PRIMARY, 8'h00);
      wr(REG_PRIMARY, 8'h01);
      rd(REG_FLAGS, 8'h08, 8'h08);
      repeat (5) @(negedge i_clk_sys);
      close_out();
   end
endmodule

// ===== test/smfh_link_sva.sv
// Assertions on the two-wire link between the master end and the slave end
`timescale 1ns/10ps
module smfh_link_sva #(
   parameter int unsigned SCL_HALF_DIV = 4
) (
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic scl,
   input wire logic frame,
   input wire logic m_sda_o,
   input wire logic m_sda_oe,
   input wire logic d_sda_o,
   input wire logic d_sda_oe,
   input wire logic sda_i
);
   logic [7:0] hi_cnt_r;
   logic       low_seen_r;

   // Length of the current high phase of the link clock
   always_ff @(posedge i_clk_sys) begin
      if (i_rst || !scl) hi_cnt_r <= 8'h00;
      else hi_cnt_r <= hi_cnt_r + 8'h01;
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) low_seen_r <= 1'b0;
      else if (!scl) low_seen_r <= 1'b1;
   end

   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);

   a_open_drain_low: assert property (!m_sda_o && !d_sda_o)
      else $error("data line driven high");
   a_line_resolve: assert property (sda_i == !(m_sda_oe || d_sda_oe))
      else $error("data line level wrong");
   a_slave_in_frame: assert property (d_sda_oe |-> frame)
      else $error("slave pulls outside a frame");
   a_master_idle: assert property (!frame && !$past(frame) |-> !m_sda_oe)
      else $error("master pulls outside a frame");
   a_frame_on_low: assert property ($changed(frame) |-> !scl)
      else $error("frame changed while clock high");
   a_data_on_low: assert property ($changed(m_sda_oe) |-> !scl)
      else $error("master data changed while clock high");
   a_ack_on_rise: assert property ($rose(d_sda_oe) |-> scl)
      else $error("acknowledge not on clock rise");
   a_ack_length: assert property ($rose(d_sda_oe) |=> d_sda_oe[*6] ##[1:3] !d_sda_oe)
      else $error("acknowledge length wrong");
   a_scl_high_len: assert property ($fell(scl) && low_seen_r |-> hi_cnt_r == 8'(SCL_HALF_DIV))
      else $error("link clock high phase wrong");

   c_ack: cover property ($rose(d_sda_oe));
   c_frame_end: cover property ($fell(frame));
   c_halt: cover property (frame && !scl [*8]);
endmodule
